// file: ser_status.sv
// status byte, standard event and questionable groups with command port
`timescale 1ns/1ns
module ser_status (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire ser_pkg::ser_cmd_t cmd_code,
	input wire logic [7:0] cmd_data,
	input wire logic errq_nonempty,
	input wire logic errq_read,
	input wire logic outq_nonempty,
	input wire logic inbuf_full,
	input wire logic outbuf_full,
	input wire logic query_err,
	input wire logic device_err,
	input wire logic exec_err,
	input wire logic command_err,
	input wire logic ops_idle,
	input wire logic [7:0] quest_cond,
	output logic resp_valid_q,
	output logic [7:0] resp_data_q,
	output logic srq_q,
	output logic errq_clear_q,
	output logic [7:0] stb_q
);
	// command decode strobes
	logic do_cls;
	logic do_rst;
	logic do_opc;
	logic ese_wr;
	logic sre_wr;
	logic qen_wr;
	logic esr_rd;
	logic qev_rd;
	logic is_query;

	// enable masks, all cleared only at power-up or by a zero write
	logic [7:0] ese_q;
	logic [7:0] sre_q;
	logic [7:0] qen_q;

	// operation complete armed, waiting for pending work
	logic opc_arm_q;

	// latched groups and their summaries
	logic [7:0] esr_q;
	logic [7:0] qev_q;
	logic esr_sum;
	logic qev_sum;

	// standard event sources as a byte
	logic [7:0] esr_set;
	logic opc_fire;
	logic [7:0] stb_now;
	logic mss;

	// true for every command that answers
	function automatic logic query_code(input ser_pkg::ser_cmd_t c);
		case (c)
			ser_pkg::SER_CMD_ESE_RD,
			ser_pkg::SER_CMD_ESR_RD,
			ser_pkg::SER_CMD_SRE_RD,
			ser_pkg::SER_CMD_STB_RD,
			ser_pkg::SER_CMD_QEV_RD,
			ser_pkg::SER_CMD_QEN_RD,
			ser_pkg::SER_CMD_QCN_RD: query_code = 1'b1;
			default: query_code = 1'b0;
		endcase
	endfunction

	// strobe for one command code
	function automatic logic hit(input logic v, input ser_pkg::ser_cmd_t c, input ser_pkg::ser_cmd_t want);
		hit = v && (c == want);
	endfunction

	// decode: one strobe per command, valid for the accepting cycle only
	assign do_cls = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_CLS);
	assign do_rst = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_RST);
	assign do_opc = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_OPC);
	assign ese_wr = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_ESE_WR);
	assign sre_wr = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_SRE_WR);
	assign qen_wr = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_QEN_WR);
	assign esr_rd = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_ESR_RD);
	assign qev_rd = hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_QEV_RD);
	assign is_query = cmd_valid && query_code(cmd_code);

	// standard event mask; only a write changes it, reads and clear-status do not
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ese_q <= ser_pkg::SER_ZERO;
		end else if (ese_wr) begin
			ese_q <= cmd_data;
		end
	end

	// status byte mask; power-up reset or a write of zero are the only ways to empty it
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			sre_q <= ser_pkg::SER_ZERO;
		end else if (sre_wr) begin
			sre_q <= cmd_data;
		end
	end

	// questionable mask, same rules as the other masks
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			qen_q <= ser_pkg::SER_ZERO;
		end else if (qen_wr) begin
			qen_q <= cmd_data;
		end
	end

	// operation complete: armed by the command, fires once work is idle
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			opc_arm_q <= 1'b0;
		end else if (opc_fire) begin
			opc_arm_q <= 1'b0;
		end else if (do_opc) begin
			opc_arm_q <= 1'b1;
		end
	end
	// the command itself counts as pending, so fire no earlier than next cycle
	assign opc_fire = opc_arm_q && ops_idle;

	// standard event sources gathered per bit
	always_comb begin
		esr_set = ser_pkg::SER_ZERO;
		esr_set[ser_pkg::SER_ESR_OPC] = opc_fire;
		// empty read, full buffers or a reported query fault
		esr_set[ser_pkg::SER_ESR_QUERY] = query_err | inbuf_full | outbuf_full
			| (errq_read & ~errq_nonempty);
		esr_set[ser_pkg::SER_ESR_DEVICE] = device_err;
		esr_set[ser_pkg::SER_ESR_EXEC] = exec_err;
		esr_set[ser_pkg::SER_ESR_CMD] = command_err;
		// reset command reports like a power cycle but clears nothing
		esr_set[ser_pkg::SER_ESR_PON] = do_rst;
	end

	// standard event group; power-on bit reads set after reset
	ser_event_latch #(
		.RESET_VAL(ser_pkg::SER_ESR_RESET)
	) u_esr (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.set_in(esr_set),
		.enable(ese_q),
		.clear(do_cls | esr_rd),
		.pulse_in(opc_fire),
		.latch_q(esr_q),
		.summary(esr_sum)
	);

	// questionable group latches its enabled conditions by level
	ser_event_latch #(
		.RESET_VAL(ser_pkg::SER_QEV_RESET)
	) u_qev (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.set_in(quest_cond),
		.enable(qen_q),
		.clear(do_cls | qev_rd),
		.pulse_in(1'b0),
		.latch_q(qev_q),
		.summary(qev_sum)
	);

	// live status byte; summaries follow the latches so a clear empties them
	always_comb begin
		stb_now = ser_pkg::SER_ZERO;
		stb_now[ser_pkg::SER_STB_ERRQ] = errq_nonempty;
		stb_now[ser_pkg::SER_STB_QSUM] = qev_sum;
		stb_now[ser_pkg::SER_STB_MAV] = outq_nonempty;
		stb_now[ser_pkg::SER_STB_ESUM] = esr_sum;
		// master summary over enabled summary bits only
		stb_now[ser_pkg::SER_STB_MSS] = |(stb_now & sre_q & ser_pkg::SER_STB_SUM_MASK);
	end
	assign mss = stb_now[ser_pkg::SER_STB_MSS];

	// registered status byte and service request
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			stb_q <= ser_pkg::SER_ZERO;
			srq_q <= 1'b0;
		end else begin
			stb_q <= stb_now;
			srq_q <= mss;
		end
	end

	// clear-status also empties the error queue outside this block
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			errq_clear_q <= 1'b0;
		end else begin
			errq_clear_q <= do_cls;
		end
	end

	// query answers, one cycle after the command; values are pre-clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			resp_valid_q <= 1'b0;
			resp_data_q <= ser_pkg::SER_ZERO;
		end else begin
			resp_valid_q <= is_query;
			case (cmd_code)
				ser_pkg::SER_CMD_ESE_RD: resp_data_q <= ese_q;
				ser_pkg::SER_CMD_ESR_RD: resp_data_q <= esr_q;
				ser_pkg::SER_CMD_SRE_RD: resp_data_q <= sre_q;
				// status byte query reads without touching the master summary
				ser_pkg::SER_CMD_STB_RD: resp_data_q <= stb_now;
				ser_pkg::SER_CMD_QEV_RD: resp_data_q <= qev_q;
				ser_pkg::SER_CMD_QEN_RD: resp_data_q <= qen_q;
				ser_pkg::SER_CMD_QCN_RD: resp_data_q <= quest_cond;
				default: resp_data_q <= resp_data_q;
			endcase
		end
	end

	// checks, one clock domain throughout
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// a reset command with no clear-status or event read in the same cycle
	sequence s_rst_cmd;
		do_rst && !do_cls && !esr_rd;
	endsequence
	// an armed operation complete meeting idle work
	sequence s_opc_done;
		opc_arm_q && ops_idle;
	endsequence

	a_rst_keeps_events: assert property (s_rst_cmd |=> (esr_q & $past(esr_q)) == $past(esr_q))
		else $error("reset command cleared an event bit");
	a_cls_keeps_masks: assert property (do_cls && !ese_wr && !sre_wr && !qen_wr
		|=> ese_q == $past(ese_q) && sre_q == $past(sre_q) && qen_q == $past(qen_q))
		else $error("clear-status changed an enable mask");
	a_read_keeps_mask: assert property (hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_ESE_RD)
		|=> ese_q == $past(ese_q) && resp_valid_q && resp_data_q == $past(ese_q))
		else $error("mask query altered or misreported mask");
	a_esr_read_clears: assert property (esr_rd && esr_set == 8'h00
		|=> (esr_q == 8'h00 && !esr_sum) ##1 !stb_q[ser_pkg::SER_STB_ESUM])
		else $error("standard event read did not clear");
	a_mav_follows: assert property ($past(resetn) |-> stb_q[ser_pkg::SER_STB_MAV] == $past(outq_nonempty)
		&& stb_q[ser_pkg::SER_STB_ERRQ] == $past(errq_nonempty))
		else $error("queue bits do not follow queues");
	a_opc_sets_bit: assert property ((s_opc_done and ese_q[ser_pkg::SER_ESR_OPC])
		|=> esr_q[ser_pkg::SER_ESR_OPC] && !opc_arm_q)
		else $error("operation complete not latched");
	a_srq_follows: assert property (##1 srq_q == $past(mss))
		else $error("service request not tracking master summary");
	a_sre_write: assert property (sre_wr |=> sre_q == $past(cmd_data) ##1 ($past(sre_wr) || sre_q == $past(sre_q)))
		else $error("status mask did not hold written value");
	a_esum_enabled: assert property ($past(resetn) |-> stb_q[ser_pkg::SER_STB_ESUM] == $past(|(esr_q & ese_q)))
		else $error("standard summary mismatch");

	// a completion still waiting on busy work
	sequence s_opc_wait;
		opc_arm_q && !ops_idle;
	endsequence

	// further checks, on latches, masks, the completion arm and what leaves the block
	// power-on bit must show right after reset whatever the mask says
	a_pon_at_reset: assert property (!$past(resetn) |-> esr_q == ser_pkg::SER_ESR_RESET)
		else $error("power-on bit missing after reset");
	// the reset command reports itself like a power cycle when enabled
	a_pon_on_rst: assert property ((s_rst_cmd and ese_q[ser_pkg::SER_ESR_PON])
		|=> esr_q[ser_pkg::SER_ESR_PON])
		else $error("reset command not reported");
	// answers come exactly one cycle after a query, never otherwise
	a_resp_valid: assert property ($past(resetn) |-> resp_valid_q == $past(is_query))
		else $error("answer strobe out of step with query");
	// a mask moves only on its own write; clear-status and reset leave it
	a_ese_only_write: assert property (!ese_wr |=> ese_q == $past(ese_q))
		else $error("standard event mask changed without write");
	a_sre_only_write: assert property (!sre_wr |=> sre_q == $past(sre_q))
		else $error("status mask changed without write");
	// clear-status empties a group unless a new event lands the same cycle
	a_cls_clears_esr: assert property (do_cls && esr_set == 8'h00
		|=> (esr_q == 8'h00) ##1 !stb_q[ser_pkg::SER_STB_ESUM])
		else $error("clear-status left standard events");
	a_cls_clears_qev: assert property (do_cls && (quest_cond & qen_q) == 8'h00
		|=> qev_q == 8'h00)
		else $error("clear-status left questionable events");
	// reading the questionable group drops its status byte summary bit two cycles later
	a_qev_read_clears: assert property (qev_rd && (quest_cond & qen_q) == 8'h00
		|=> (qev_q == 8'h00) ##1 !stb_q[ser_pkg::SER_STB_QSUM])
		else $error("questionable read did not clear summary");
	// questionable summary counts enabled latched bits only
	a_qsum_enabled: assert property ($past(resetn)
		|-> stb_q[ser_pkg::SER_STB_QSUM] == $past(|(qev_q & qen_q)))
		else $error("questionable summary mismatch");
	// master summary from the registered byte and last cycle's mask
	a_mss_enabled: assert property ($past(resetn)
		|-> stb_q[ser_pkg::SER_STB_MSS] == |(stb_q & $past(sre_q) & ser_pkg::SER_STB_SUM_MASK))
		else $error("master summary mismatch");
	// a status byte query answers with the byte itself, master summary kept
	a_stb_answer: assert property (hit(cmd_valid, cmd_code, ser_pkg::SER_CMD_STB_RD)
		|=> resp_valid_q && resp_data_q == stb_q)
		else $error("status byte answer differs from status byte");
	// completion stays armed while work is pending; firing early is the hazard
	a_opc_waits: assert property (s_opc_wait |=> opc_arm_q)
		else $error("operation complete fired while busy");
	// error queue clear follows clear-status by one cycle
	a_errq_clear: assert property ($past(resetn) |-> errq_clear_q == $past(do_cls))
		else $error("error queue clear out of step");
endmodule // ser_status

// file: ser_pkg.sv
// constants, command codes and bit layout for the status event reporting block
//
// Contract
// - event bits latch and stay set
// - event query or clear-status clears event bits
// - reset command leaves event bits unchanged (code clears none but sets bit 7 when enabled)
// - enable masks readable, writable, reads keep value
// - clear-status leaves every enable mask alone
// - event bit latches only when enabled
// - status bit 4 set while output queued
// - message bit clears once output drained
// - clearing event group clears its summary
// - status bit 2 set while errors queued
// - status bit 3 summarises enabled questionable
// - status bit 5 summarises enabled standard events
// - status bit 6 summarises enabled summaries
// - clear-status or event reads clear status byte (code clears only the summary bits of the groups it clears; message bit stays)
// - status byte mask cleared only by writing zero
// - operation complete set once pending work finishes
// - query error on empty read or full buffers
// - bits 3,4,5: device, execution, command faults
// - bit 7 set after power-up or reset
// - enabled standard event sets summary bit
// - standard events cleared by clear-status or read
// - standard event mask cleared only by writing zero
// - status byte query keeps master summary bit
package ser_pkg;
	// width of every status register
	localparam int unsigned SER_W = 8;
	// command codes presented on the command port
	typedef enum logic [3:0] {
		SER_CMD_NOP = 4'h0, // no operation
		SER_CMD_CLS = 4'h1, // clear status
		SER_CMD_RST = 4'h2, // unit reset command
		SER_CMD_OPC = 4'h3, // arm operation complete
		SER_CMD_ESE_WR = 4'h4, // write standard event mask
		SER_CMD_ESE_RD = 4'h5, // query standard event mask
		SER_CMD_ESR_RD = 4'h6, // query and clear standard events
		SER_CMD_SRE_WR = 4'h7, // write status byte mask
		SER_CMD_SRE_RD = 4'h8, // query status byte mask
		SER_CMD_STB_RD = 4'h9, // query status byte
		SER_CMD_QEV_RD = 4'hA, // query and clear questionable events
		SER_CMD_QEN_WR = 4'hB, // write questionable mask
		SER_CMD_QEN_RD = 4'hC, // query questionable mask
		SER_CMD_QCN_RD = 4'hD // query questionable condition
	} ser_cmd_t;
	// status byte bit positions
	localparam int unsigned SER_STB_ERRQ = 2;
	localparam int unsigned SER_STB_QSUM = 3;
	localparam int unsigned SER_STB_MAV = 4;
	localparam int unsigned SER_STB_ESUM = 5;
	localparam int unsigned SER_STB_MSS = 6;
	// standard event bit positions
	localparam int unsigned SER_ESR_OPC = 0;
	localparam int unsigned SER_ESR_QUERY = 2;
	localparam int unsigned SER_ESR_DEVICE = 3;
	localparam int unsigned SER_ESR_EXEC = 4;
	localparam int unsigned SER_ESR_CMD = 5;
	localparam int unsigned SER_ESR_PON = 7;
	// reset values
	localparam logic [7:0] SER_ZERO = 8'h00;
	localparam logic [7:0] SER_ESR_RESET = 8'h80; // power-on bit shows after reset
	localparam logic [7:0] SER_QEV_RESET = 8'h00;
	// summary bits that may feed the master summary
	localparam logic [7:0] SER_STB_SUM_MASK = 8'h3C;
endpackage : ser_pkg

// file: ser_event_latch.sv
// sticky event register with enable gating and summary output
`timescale 1ns/1ns
module ser_event_latch #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [7:0] set_in,
	input wire logic [7:0] enable,
	input wire logic clear,
	input wire logic pulse_in,
	output logic [7:0] latch_q,
	output logic summary
);
	// incoming events that the mask allows through
	logic [7:0] gated;
	// a lone extra source folds into bit 0 and obeys the same mask
	assign gated = (set_in | {7'h00, pulse_in}) & enable;

	// sticky latch; a set arriving with the clear wins so no event is lost
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			latch_q <= RESET_VAL;
		end else if (clear) begin
			latch_q <= gated;
		end else begin
			latch_q <= latch_q | gated;
		end
	end

	// summary of enabled latched bits, drops as soon as the latch clears
	assign summary = |(latch_q & enable);

	// a latched bit stays until a clear
	a_latch_sticky: assert property (@(posedge clk_sys) disable iff (!resetn)
		!clear |=> (latch_q & $past(latch_q)) == $past(latch_q))
		else $error("event bit dropped without clear");
	// masked-off bit never appears from nothing
	a_latch_gated: assert property (@(posedge clk_sys) disable iff (!resetn)
		##1 ((latch_q & ~$past(latch_q) & ~$past(enable)) == 8'h00))
		else $error("event bit latched while disabled");
endmodule // ser_event_latch

// file: ser_host_model.sv
// host controller model issuing status commands
`timescale 1ns/1ns
module ser_host_model (
	input wire logic clk_sys,
	output logic cmd_valid,
	output ser_pkg::ser_cmd_t cmd_code,
	output logic [7:0] cmd_data
);
	// idle state before the first command
	initial begin
		cmd_valid = 1'b0;
		cmd_code = ser_pkg::SER_CMD_NOP;
		cmd_data = 8'hFF;
	end
	// one strobe per command, launched and dropped on falling edges
	task automatic issue(input ser_pkg::ser_cmd_t c, input logic [7:0] d);
		@(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_data = d;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		// inverted data so a stale byte is never mistaken for a live one
		cmd_data = ~d;
	endtask
endmodule // ser_host_model

// file: ser_status_test.sv
// self-checking bench for the status event block
`timescale 1ns/1ns
module ser_status_test;
	logic clk_sys, resetn, cmd_valid, errq_nonempty, errq_read, outq_nonempty;
	logic inbuf_full, outbuf_full, ops_idle, resp_valid_q, srq_q, errq_clear_q;
	logic [3:0] ev; // query, device, execution, command faults
	logic [7:0] cmd_data, quest_cond, resp_data_q, stb_q, m, c;
	ser_pkg::ser_cmd_t cmd_code;
	logic [7:0] exp_q[$]; // answers expected, oldest first
	int num_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	ser_host_model u_host (.clk_sys, .cmd_valid, .cmd_code, .cmd_data);
	ser_status u_dut (.clk_sys, .resetn, .cmd_valid, .cmd_code, .cmd_data, .errq_nonempty,
		.errq_read, .outq_nonempty, .inbuf_full, .outbuf_full, .query_err(ev[0]),
		.device_err(ev[1]), .exec_err(ev[2]), .command_err(ev[3]), .ops_idle, .quest_cond,
		.resp_valid_q, .resp_data_q, .srq_q, .errq_clear_q, .stb_q);
	// 40 ns clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// hang guard, well above the fewer than two hundred cycles the run needs
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			num_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] e, input string s);
		cmp_count++;
		if (got !== e) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, s, got, e);
		end
	endtask
	// answers compared against the oldest note
	always @(negedge clk_sys) begin
		if (resp_valid_q === 1'b1) begin
			if (exp_q.size() == 0)
				chk(8'h00, 8'hFF, "answer with no query");
			else
				chk(resp_data_q, exp_q.pop_front(), "answer");
		end
	end
	task automatic rd(input ser_pkg::ser_cmd_t k, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.issue(k, 8'h00);
	endtask
	task automatic wr(input ser_pkg::ser_cmd_t k, input logic [7:0] d);
		u_host.issue(k, d);
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// one-cycle fault pulse
	task automatic pulse(input logic [3:0] v);
		@(negedge clk_sys);
		ev = v;
		@(negedge clk_sys);
		ev = 4'h0;
	endtask
	task automatic end_sim;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		{resetn, errq_nonempty, errq_read, outq_nonempty, inbuf_full, outbuf_full} = 6'h00;
		ops_idle = 1'b1;
		ev = 4'h0;
		quest_cond = 8'h00;
		void'($urandom(34));
		w(10);
		resetn = 1'b1;
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h80);
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h00);
		pulse(4'h4);
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h00);
		// standard event mask read back twice, the other masks once, value kept
		for (int i = 0; i < 3; i++) begin
			m = 8'($urandom);
			wr(ser_pkg::SER_CMD_ESE_WR, m);
			wr(ser_pkg::SER_CMD_SRE_WR, ~m);
			wr(ser_pkg::SER_CMD_QEN_WR, m ^ 8'h5A);
			rd(ser_pkg::SER_CMD_ESE_RD, m);
			rd(ser_pkg::SER_CMD_SRE_RD, ~m);
			rd(ser_pkg::SER_CMD_QEN_RD, m ^ 8'h5A);
			rd(ser_pkg::SER_CMD_ESE_RD, m);
		end
		wr(ser_pkg::SER_CMD_ESE_WR, 8'h3D);
		for (int i = 0; i < 4; i++)
			pulse(4'h1 << i);
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h3C);
		// empty error queue read, then each full buffer
		for (int i = 0; i < 3; i++) begin
			{errq_read, inbuf_full, outbuf_full} = 3'b100 >> i;
			w(1);
			{errq_read, inbuf_full, outbuf_full} = 3'b000;
			rd(ser_pkg::SER_CMD_ESR_RD, 8'h04);
		end
		// completion waits for idle
		ops_idle = 1'b0;
		wr(ser_pkg::SER_CMD_OPC, 8'h00);
		w(3);
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h00);
		ops_idle = 1'b1;
		w(3);
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h01);
		// status byte summaries
		wr(ser_pkg::SER_CMD_SRE_WR, 8'h3C);
		errq_nonempty = 1'b1;
		w(3);
		chk({7'h00, srq_q}, 8'h01, "service request");
		rd(ser_pkg::SER_CMD_STB_RD, 8'h44);
		chk(stb_q, 8'h44, "status byte");
		outq_nonempty = 1'b1;
		w(3);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h54);
		chk(stb_q, 8'h54, "status byte");
		{errq_nonempty, outq_nonempty} = 2'b00;
		w(3);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h00);
		chk(stb_q, 8'h00, "status byte");
		chk({7'h00, srq_q}, 8'h00, "service request");
		pulse(4'h4);
		w(2);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h60);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h60);
		chk(stb_q, 8'h60, "status byte");
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h10);
		w(2);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h00);
		// questionable group with random mask and condition
		m = 8'($urandom) | 8'h01;
		c = 8'($urandom) | m;
		wr(ser_pkg::SER_CMD_QEN_WR, m);
		quest_cond = c;
		w(3);
		rd(ser_pkg::SER_CMD_QCN_RD, c);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h48);
		chk(stb_q, 8'h48, "status byte");
		quest_cond = 8'h00;
		w(2);
		rd(ser_pkg::SER_CMD_QEV_RD, m);
		w(2);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h00);
		// clear-status keeps masks, reset command keeps events
		pulse(4'h4);
		wr(ser_pkg::SER_CMD_NOP, 8'hFF);
		wr(ser_pkg::SER_CMD_CLS, 8'h00);
		chk({7'h00, errq_clear_q}, 8'h01, "error queue clear");
		w(2);
		chk({7'h00, errq_clear_q}, 8'h00, "error queue clear");
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h00);
		rd(ser_pkg::SER_CMD_STB_RD, 8'h00);
		rd(ser_pkg::SER_CMD_ESE_RD, 8'h3D);
		rd(ser_pkg::SER_CMD_SRE_RD, 8'h3C);
		wr(ser_pkg::SER_CMD_ESE_WR, 8'hBD);
		pulse(4'h4);
		wr(ser_pkg::SER_CMD_RST, 8'h00);
		w(2);
		rd(ser_pkg::SER_CMD_ESR_RD, 8'h90);
		wr(ser_pkg::SER_CMD_SRE_WR, 8'h00);
		rd(ser_pkg::SER_CMD_SRE_RD, 8'h00);
		wr(ser_pkg::SER_CMD_ESE_WR, 8'h00);
		rd(ser_pkg::SER_CMD_ESE_RD, 8'h00);
		w(4);
		chk(8'(exp_q.size()), 8'h00, "answers missing");
		end_sim();
	end
endmodule // ser_status_test
